/* File: hw/ptc_top.sv */
`timescale 1ns/1ps
`default_nettype none
module ptc_top #(
	parameter int REF_DIV = ptc_pkg::REF_DIV_DEF
) (
	input  wire logic                       ref_clk,
	input  wire logic                       sys_rst,
	input  wire logic [ptc_pkg::ADDR_W-1:0] s_axi_awaddr,
	input  wire logic                       s_axi_awvalid,
	output logic                            s_axi_awready,
	input  wire logic [31:0]                s_axi_wdata,
	input  wire logic [3:0]                 s_axi_wstrb,
	input  wire logic                       s_axi_wvalid,
	output logic                            s_axi_wready,
	output logic      [1:0]                 s_axi_bresp,
	output logic                            s_axi_bvalid,
	input  wire logic                       s_axi_bready,
	input  wire logic [ptc_pkg::ADDR_W-1:0] s_axi_araddr,
	input  wire logic                       s_axi_arvalid,
	output logic                            s_axi_arready,
	output logic      [31:0]                s_axi_rdata,
	output logic      [1:0]                 s_axi_rresp,
	output logic                            s_axi_rvalid,
	input  wire logic                       s_axi_rready,
	input  wire logic                       rxFrameValid,
	input  wire logic                       rxIsPtp,
	input  wire logic [3:0]                 rxVersion,
	input  wire logic [3:0]                 rxMsgType,
	input  wire logic                       rxOverUdp4,
	input  wire logic                       rxOverUdp6,
	input  wire logic                       rxOverEther,
	input  wire logic                       rxDaMatch,
	input  wire logic                       txFrameValid,
	output logic                            rxSnap,
	output logic      [31:0]                rxStampSec,
	output logic      [30:0]                rxStampSub,
	output logic                            txSnap,
	output logic      [31:0]                txStampSec,
	output logic      [30:0]                txStampSub,
	output logic                            stampIrq
);
	import ptc_pkg::*;
	localparam int DONE_WAIT = REF_DIV + 2;

	logic [31:0]       ctrl;
	logic [7:0]        step;
	logic [31:0]       updSec;
	logic [31:0]       updSubW;
	logic [31:0]       addend;
	logic [31:0]       tgtSec;
	logic [30:0]       tgtSub;
	logic [ADDR_W-1:0] awAddr;
	logic [31:0]       wData;
	logic [3:0]        wStrb;
	logic              awFull;
	logic              wFull;
	logic              doWrite;
	logic              ctrlWr;
	logic [31:0]       wMerged;
	logic [31:0]       doneMask;
	logic [31:0]       sec;
	logic [30:0]       sub;
	logic              loadDone;
	logic              adjDone;
	logic              addendDone;
	logic              tgtHit;
	logic              tick;
	logic [7:0]        divCnt;

	// byte-lane merge for partial writes
	function automatic logic [31:0] mergeBytes(input logic [31:0] old, input logic [31:0] d,
		input logic [3:0] s);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (s[i])
				r[8*i+:8] = d[8*i+:8];
		end
		return r;
	endfunction

	// address decode shared by both paths
	function automatic logic mapped(input logic [ADDR_W-1:0] a);
		case (a)
			A_CTRL, A_STEP, A_SEC, A_SUB, A_USEC, A_USUB, A_ADDEND, A_TSEC, A_TSUB: return 1'b1;
			default: return 1'b0;
		endcase
	endfunction

	// register read view; write merge uses it for the old contents
	function automatic logic [31:0] regValue(input logic [ADDR_W-1:0] a);
		case (a)
			A_CTRL:   return ctrl;
			A_STEP:   return {24'h00_0000, step};
			A_SEC:    return sec;
			A_SUB:    return {1'b0, sub};
			A_USEC:   return updSec;
			A_USUB:   return updSubW;
			A_ADDEND: return addend;
			A_TSEC:   return tgtSec;
			A_TSUB:   return {1'b0, tgtSub};
			default:  return 32'h0000_0000;
		endcase
	endfunction

	assign doWrite = awFull & wFull & ~s_axi_bvalid;
	assign ctrlWr  = doWrite & (awAddr == A_CTRL);
	assign doneMask = (32'(loadDone) << B_LOAD) | (32'(adjDone) << B_ADJ)
		| (32'(tgtHit) << B_ARM) | (32'(addendDone) << B_ADDEND);
	// a process, not an assign, so it also wakes on the registers read inside the function
	always_comb wMerged = mergeBytes(regValue(awAddr), wData, wStrb);

	// write address channel; ready drops until the response is taken
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			s_axi_awready <= 1'b1;
			awFull        <= 1'b0;
			awAddr        <= '0;
		end else if (s_axi_awvalid & s_axi_awready) begin
			s_axi_awready <= 1'b0;
			awFull        <= 1'b1;
			awAddr        <= s_axi_awaddr;
		end else if (doWrite) begin
			awFull <= 1'b0;
		end else if (s_axi_bvalid & s_axi_bready) begin
			s_axi_awready <= 1'b1;
		end
	end

	// write data channel, independent of the address
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			s_axi_wready <= 1'b1;
			wFull        <= 1'b0;
			wData        <= 32'h0000_0000;
			wStrb        <= 4'h0;
		end else if (s_axi_wvalid & s_axi_wready) begin
			s_axi_wready <= 1'b0;
			wFull        <= 1'b1;
			wData        <= s_axi_wdata;
			wStrb        <= s_axi_wstrb;
		end else if (doWrite) begin
			wFull <= 1'b0;
		end else if (s_axi_bvalid & s_axi_bready) begin
			s_axi_wready <= 1'b1;
		end
	end

	// write response
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RESP_OKAY;
		end else if (doWrite) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= mapped(awAddr) ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bvalid & s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// read channel, one cycle from address to data
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= RESP_OKAY;
		end else if (s_axi_arvalid & s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rdata   <= regValue(s_axi_araddr);
			s_axi_rresp   <= mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rvalid & s_axi_rready) begin
			s_axi_rvalid  <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	// control: plain bits stored, request bits set by software and cleared on completion;
	// a fresh set in the completion cycle survives, reserved bits never store
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst)
			ctrl <= CTRL_RESET;
		else if (ctrlWr)
			ctrl <= (wMerged & CTRL_RW_MASK) | (((ctrl & ~doneMask) | wMerged) & CTRL_SC_MASK);
		else
			ctrl <= ctrl & ~doneMask;
	end

	// time parameter registers
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			step    <= 8'h00;
			updSec  <= 32'h0000_0000;
			updSubW <= 32'h0000_0000;
			addend  <= 32'h0000_0000;
			tgtSec  <= 32'h0000_0000;
			tgtSub  <= 31'h0000_0000;
		end else if (doWrite) begin
			case (awAddr)
				A_STEP:   step    <= wMerged[7:0];
				A_USEC:   updSec  <= wMerged;
				A_USUB:   updSubW <= wMerged;
				A_ADDEND: addend  <= wMerged;
				A_TSEC:   tgtSec  <= wMerged;
				A_TSUB:   tgtSub  <= wMerged[30:0];
				default: ;
			endcase
		end
	end

	// reference time clock as an enable; avoids a second clock domain entirely
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			divCnt <= 8'h00;
			tick   <= 1'b0;
		end else begin
			divCnt <= (divCnt == 8'(REF_DIV - 1)) ? 8'h00 : divCnt + 8'h01;
			tick   <= divCnt == 8'(REF_DIV - 1);
		end
	end

	// frame stamps taken on the frame's start pulse
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			txSnap     <= 1'b0;
			txStampSec <= 32'h0000_0000;
			txStampSub <= 31'h0000_0000;
			rxStampSec <= 32'h0000_0000;
			rxStampSub <= 31'h0000_0000;
			stampIrq   <= 1'b0;
		end else begin
			txSnap   <= txFrameValid & ctrl[B_STAMP_ON];
			stampIrq <= tgtHit;
			if (txFrameValid & ctrl[B_STAMP_ON]) begin
				txStampSec <= sec;
				txStampSub <= sub;
			end
			if (rxFrameValid) begin
				rxStampSec <= sec;
				rxStampSub <= sub;
			end
		end
	end

	ptc_time_gen u_time (
		.ref_clk    (ref_clk),
		.sys_rst    (sys_rst),
		.tick       (tick),
		.run        (ctrl[B_STAMP_ON]),
		.fine       (ctrl[B_FINE]),
		.decimal    (ctrl[B_DEC]),
		.step       (step),
		.addend     (addend),
		.loadReq    (ctrl[B_LOAD]),
		.adjReq     (ctrl[B_ADJ]),
		.addendReq  (ctrl[B_ADDEND]),
		.subtract   (updSubW[B_SUBTRACT]),
		.updSec     (updSec),
		.updSub     (updSubW[30:0]),
		.armed      (ctrl[B_ARM]),
		.tgtSec     (tgtSec),
		.tgtSub     (tgtSub),
		.sec        (sec),
		.sub        (sub),
		.loadDone   (loadDone),
		.adjDone    (adjDone),
		.addendDone (addendDone),
		.tgtHit     (tgtHit)
	);

	ptc_rx_snoop u_snoop (
		.ref_clk      (ref_clk),
		.sys_rst      (sys_rst),
		.ctrl         (ctrl),
		.rxFrameValid (rxFrameValid),
		.rxIsPtp      (rxIsPtp),
		.rxVersion    (rxVersion),
		.rxMsgType    (rxMsgType),
		.rxOverUdp4   (rxOverUdp4),
		.rxOverUdp6   (rxOverUdp6),
		.rxOverEther  (rxOverEther),
		.rxDaMatch    (rxDaMatch),
		.rxSnap       (rxSnap)
	);

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	property p_tx_on;
		txFrameValid & ctrl[B_STAMP_ON] |=> txSnap && txStampSec == $past(sec);
	endproperty
	a_tx_on: assert property (p_tx_on) else $error("transmit frame not stamped");
	property p_tx_off;
		txFrameValid & ~ctrl[B_STAMP_ON] |=> ~txSnap;
	endproperty
	a_tx_off: assert property (p_tx_off) else $error("transmit stamp while off");
	property p_arm;
		tgtHit & ~ctrlWr |=> ~ctrl[B_ARM] && stampIrq;
	endproperty
	a_arm: assert property (p_arm) else $error("target hit not handled");
	property p_hold;
		ctrl[B_LOAD] & ~loadDone |=> ctrl[B_LOAD];
	endproperty
	a_hold: assert property (p_hold) else $error("load bit dropped early");
	property p_adj;
		adjDone & ~ctrlWr |=> ~ctrl[B_ADJ];
	endproperty
	a_adj: assert property (p_adj) else $error("adjust bit not cleared");
	property p_load_done;
		$rose(ctrl[B_LOAD]) |-> ##[1:DONE_WAIT] loadDone;
	endproperty
	a_load_done: assert property (p_load_done) else $error("load not served");
	property p_reset;
		$fell(sys_rst) |-> ctrl == CTRL_RESET;
	endproperty
	a_reset: assert property (p_reset) else $error("control reset value wrong");
endmodule
`default_nettype wire

/* File: hw/ptc_pkg.sv */
package ptc_pkg;
	// register map, byte addresses
	localparam int          ADDR_W   = 12;
	localparam logic [11:0] A_CTRL   = 12'h0700;
	localparam logic [11:0] A_STEP   = 12'h0704;
	localparam logic [11:0] A_SEC    = 12'h0708;
	localparam logic [11:0] A_SUB    = 12'h070C;
	localparam logic [11:0] A_USEC   = 12'h0710;
	localparam logic [11:0] A_USUB   = 12'h0714;
	localparam logic [11:0] A_ADDEND = 12'h0718;
	localparam logic [11:0] A_TSEC   = 12'h071C;
	localparam logic [11:0] A_TSUB   = 12'h0720;
	// control register fields
	localparam int B_STAMP_ON = 0;
	localparam int B_FINE     = 1;
	localparam int B_LOAD     = 2;
	localparam int B_ADJ      = 3;
	localparam int B_ARM      = 4;
	localparam int B_ADDEND   = 5;
	localparam int B_EVERY    = 8;
	localparam int B_DEC      = 9;
	localparam int B_V2       = 10;
	localparam int B_RAW      = 11;
	localparam int B_IP6      = 12;
	localparam int B_IP4      = 13;
	localparam int B_EVT      = 14;
	localparam int B_MASTER   = 15;
	localparam int B_CLASS    = 16;
	localparam int B_DAF      = 18;
	localparam int B_SUBTRACT = 31;
	localparam logic [31:0] CTRL_RESET   = 32'h0000_2000;
	localparam logic [31:0] CTRL_RW_MASK = 32'h0007_FF03;
	localparam logic [31:0] CTRL_SC_MASK = 32'h0000_003C;
	// sub-second rollover points
	localparam logic [30:0] SUB_MAX_DEC = 31'h3B9A_C9FF;
	localparam logic [30:0] SUB_MAX_BIN = 31'h7FFF_FFFF;
	// message type codes as parsed by the receive path
	localparam logic [3:0] MSG_SYNC   = 4'h0;
	localparam logic [3:0] MSG_DREQ   = 4'h1;
	localparam logic [3:0] MSG_PDREQ  = 4'h2;
	localparam logic [3:0] MSG_PDRESP = 4'h3;
	localparam logic [3:0] MSG_FUP    = 4'h8;
	localparam logic [3:0] MSG_DRESP  = 4'h9;
	localparam logic [3:0] MSG_PDRFU  = 4'hA;
	localparam logic [3:0] VER_ONE    = 4'h1;
	localparam logic [3:0] VER_TWO    = 4'h2;
	// reference time clock = system clock / REF_DIV
	localparam int         REF_DIV_DEF = 2;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* File: hw/ptc_time_gen.sv */
`timescale 1ns/1ps
`default_nettype none
module ptc_time_gen (
	input  wire logic        ref_clk,
	input  wire logic        sys_rst,
	input  wire logic        tick,
	input  wire logic        run,
	input  wire logic        fine,
	input  wire logic        decimal,
	input  wire logic [7:0]  step,
	input  wire logic [31:0] addend,
	input  wire logic        loadReq,
	input  wire logic        adjReq,
	input  wire logic        addendReq,
	input  wire logic        subtract,
	input  wire logic [31:0] updSec,
	input  wire logic [30:0] updSub,
	input  wire logic        armed,
	input  wire logic [31:0] tgtSec,
	input  wire logic [30:0] tgtSub,
	output logic      [31:0] sec,
	output logic      [30:0] sub,
	output logic             loadDone,
	output logic             adjDone,
	output logic             addendDone,
	output logic             tgtHit
);
	import ptc_pkg::*;
	logic [31:0] acc;
	logic [31:0] addendLive;
	logic [30:0] subMax;
	logic [32:0] accSum;
	logic [31:0] incSum;
	logic [31:0] adjAdd;
	logic [31:0] adjSubt;
	logic        advance;
	logic        after;
	logic        doLoad;
	logic        doAdj;
	logic        doAddend;

	assign subMax  = decimal ? SUB_MAX_DEC : SUB_MAX_BIN;
	assign accSum  = {1'b0, acc} + {1'b0, addendLive};
	assign advance = run & (~fine | accSum[32]);
	assign incSum  = {1'b0, sub} + {24'h00_0000, step};
	assign adjAdd  = {1'b0, sub} + {1'b0, updSub};
	assign adjSubt = {1'b0, sub} - {1'b0, updSub};
	assign after   = (sec > tgtSec) | ((sec == tgtSec) & (sub > tgtSub));
	// a request bit still reads high in its done cycle; serving it again would add twice
	assign doLoad   = tick & loadReq & ~loadDone;
	assign doAdj    = tick & adjReq & ~loadReq & ~adjDone;
	assign doAddend = tick & addendReq & ~addendDone;

	// system time; requests are served on reference ticks only
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			sec      <= 32'h0000_0000;
			sub      <= 31'h0000_0000;
			loadDone <= 1'b0;
			adjDone  <= 1'b0;
		end else begin
			loadDone <= doLoad;
			adjDone  <= doAdj;
			if (tick) begin
				if (doLoad) begin
					sec <= updSec;
					sub <= updSub;
				end else if (doAdj & subtract) begin
					// borrow out of the sub-seconds
					sub <= adjSubt[31] ? adjSubt[30:0] + subMax + 31'h0000_0001 : adjSubt[30:0];
					sec <= sec - updSec - {31'h0000_0000, adjSubt[31]};
				end else if (doAdj) begin
					sub <= (adjAdd > {1'b0, subMax}) ? 31'(adjAdd - {1'b0, subMax} - 32'h0000_0001)
						: adjAdd[30:0];
					sec <= sec + updSec + {31'h0000_0000, adjAdd > {1'b0, subMax}};
				end else if (advance) begin
					if (incSum > {1'b0, subMax}) begin
						sub <= 31'(incSum - {1'b0, subMax} - 32'h0000_0001);
						sec <= sec + 32'h0000_0001;
					end else begin
						sub <= incSum[30:0];
					end
				end
			end
		end
	end

	// fine accumulator and its addend copy
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			acc        <= 32'h0000_0000;
			addendLive <= 32'h0000_0000;
			addendDone <= 1'b0;
		end else begin
			addendDone <= doAddend;
			if (doAddend)
				addendLive <= addend;
			if (tick & run & fine)
				acc <= accSum[31:0];
		end
	end

	// one pulse per crossing; guard stops a repeat while the arm bit drops
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst)
			tgtHit <= 1'b0;
		else
			tgtHit <= tick & armed & run & after & ~tgtHit;
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	property p_load;
		tick & loadReq & ~loadDone |=> sec == $past(updSec) && sub == $past(updSub) && loadDone;
	endproperty
	a_load: assert property (p_load) else $error("time load not applied");
	property p_wrap;
		tick & run & ~fine & ~loadReq & ~adjReq & (incSum > {1'b0, subMax})
			|=> sec == $past(sec) + 32'h0000_0001 && sub < $past(sub);
	endproperty
	a_wrap: assert property (p_wrap) else $error("sub-second wrap wrong");
	property p_fine;
		tick & run & fine & ~accSum[32] & ~loadReq & ~adjReq |=> $stable(sub) && $stable(sec);
	endproperty
	a_fine: assert property (p_fine) else $error("time moved without overflow");
	property p_halt;
		tick & ~run & ~loadReq & ~adjReq |=> $stable(sub) && $stable(sec);
	endproperty
	a_halt: assert property (p_halt) else $error("time moved while off");
endmodule
`default_nettype wire

/* File: hw/ptc_rx_snoop.sv */
`timescale 1ns/1ps
`default_nettype none
module ptc_rx_snoop (
	input  wire logic        ref_clk,
	input  wire logic        sys_rst,
	input  wire logic [31:0] ctrl,
	input  wire logic        rxFrameValid,
	input  wire logic        rxIsPtp,
	input  wire logic [3:0]  rxVersion,
	input  wire logic [3:0]  rxMsgType,
	input  wire logic        rxOverUdp4,
	input  wire logic        rxOverUdp6,
	input  wire logic        rxOverEther,
	input  wire logic        rxDaMatch,
	output logic             rxSnap
);
	import ptc_pkg::*;
	logic typeOk;
	logic encOk;
	logic verOk;
	logic slaveEvt;

	// message class table
	assign slaveEvt = ctrl[B_MASTER] ? (rxMsgType == MSG_DREQ) : (rxMsgType == MSG_SYNC);
	always_comb begin
		unique case (ctrl[B_CLASS+:2])
			2'b00: typeOk = ctrl[B_EVT] ? slaveEvt : (rxMsgType == MSG_SYNC)
				| (rxMsgType == MSG_FUP) | (rxMsgType == MSG_DREQ) | (rxMsgType == MSG_DRESP);
			2'b01: typeOk = (ctrl[B_EVT] ? slaveEvt : ((rxMsgType == MSG_SYNC)
				| (rxMsgType == MSG_FUP) | (rxMsgType == MSG_DREQ) | (rxMsgType == MSG_DRESP)
				| (rxMsgType == MSG_PDRFU))) | (rxMsgType == MSG_PDREQ) | (rxMsgType == MSG_PDRESP);
			2'b10: typeOk = (rxMsgType == MSG_SYNC) | (rxMsgType == MSG_DREQ);
			2'b11: typeOk = (rxMsgType == MSG_PDREQ) | (rxMsgType == MSG_PDRESP);
		endcase
	end
	// raw frames need the address match only when the filter is on
	assign encOk = (rxOverUdp4 & ctrl[B_IP4]) | (rxOverUdp6 & ctrl[B_IP6])
		| (rxOverEther & ctrl[B_RAW] & (~ctrl[B_DAF] | rxDaMatch));
	assign verOk = rxVersion == (ctrl[B_V2] ? VER_TWO : VER_ONE);

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst)
			rxSnap <= 1'b0;
		else
			rxSnap <= rxFrameValid & ctrl[B_STAMP_ON]
				& (ctrl[B_EVERY] | (rxIsPtp & encOk & verOk & typeOk));
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	property p_every;
		rxFrameValid & ctrl[B_STAMP_ON] & ctrl[B_EVERY] |=> rxSnap;
	endproperty
	a_every: assert property (p_every) else $error("frame not stamped");
	property p_daf;
		rxFrameValid & ctrl[B_DAF] & ~ctrl[B_EVERY] & rxOverEther & ~rxOverUdp4
			& ~rxOverUdp6 & ~rxDaMatch |=> ~rxSnap;
	endproperty
	a_daf: assert property (p_daf) else $error("unmatched raw frame stamped");
	property p_rxoff;
		rxFrameValid & ~ctrl[B_STAMP_ON] |=> ~rxSnap;
	endproperty
	a_rxoff: assert property (p_rxoff) else $error("stamp while off");
endmodule
`default_nettype wire

/* File: dv/ptc_mac_model.sv */
`timescale 1ns/1ps
`default_nettype none
// receive and transmit path stand-in; the parse fields mean something only with a pulse
module ptc_mac_model (
	input  wire logic        ref_clk,
	input  wire logic        go,
	input  wire logic        tx,
	input  wire logic [11:0] f,
	output logic             rxFrameValid,
	output logic             rxIsPtp,
	output logic      [3:0]  rxVersion,
	output logic      [3:0]  rxMsgType,
	output logic             rxOverUdp4,
	output logic             rxOverUdp6,
	output logic             rxOverEther,
	output logic             rxDaMatch,
	output logic             txFrameValid
);
	logic [11:0] pat = 12'h05A5;
	logic [11:0] v;
	// fields toggle between frames so a stale value never looks valid by luck
	always @(posedge ref_clk) pat <= ~pat;
	assign v = go ? f : pat;
	assign rxFrameValid = go;
	assign txFrameValid = tx;
	assign rxIsPtp = v[0];
	assign rxVersion = {2'h0, v[2:1]};
	assign rxMsgType = v[6:3];
	// at most one carrier per frame, none when v[8:7] is 3, as a real parser reports
	assign rxOverUdp4 = v[8:7] == 2'h0;
	assign rxOverUdp6 = v[8:7] == 2'h1;
	assign rxOverEther = v[8:7] == 2'h2;
	assign rxDaMatch = v[10];
endmodule
`default_nettype wire

/* File: dv/ptp_system_time_control_test.sv */
`timescale 1ns/1ps
`default_nettype none
module ptp_system_time_control_test;
	import ptc_pkg::*;
	logic        ref_clk = 1'b0, sys_rst = 1'b0, go = 1'b0, tx = 1'b0;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [11:0] awaddr = 12'h000, araddr = 12'h000;
	logic [31:0] wdata = 32'h0000_0000, f = 32'h0000_0000, seed = 32'h0001_6F8F;
	logic [31:0] rd0, rd1, c, ps, lim, rdata, txStampSec, rxStampSec;
	logic [30:0] pu, txStampSub, rxStampSub;
	logic [1:0]  rr, bresp, rresp;
	logic        awready, wready, bvalid, arready, rvalid, rxSnap, txSnap, stampIrq;
	logic        rxFrameValid, rxIsPtp, rxOverUdp4, rxOverUdp6, rxOverEther, rxDaMatch;
	logic        txFrameValid;
	logic [3:0]  rxVersion, rxMsgType;
	int          errCount = 0, checkCount = 0, n;
	// reference tick every clock so stamps one cycle apart differ by one step
	ptc_top #(.REF_DIV(1)) ptc_top_i (.ref_clk, .sys_rst, .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .rxFrameValid,
		.rxIsPtp, .rxVersion, .rxMsgType, .rxOverUdp4, .rxOverUdp6, .rxOverEther, .rxDaMatch,
		.txFrameValid, .rxSnap, .rxStampSec, .rxStampSub, .txSnap, .txStampSec,
		.txStampSub, .stampIrq);
	ptc_mac_model ptc_mac_model_i (.ref_clk, .go, .tx, .f(f[11:0]), .rxFrameValid, .rxIsPtp,
		.rxVersion, .rxMsgType, .rxOverUdp4, .rxOverUdp6, .rxOverEther, .rxDaMatch, .txFrameValid);
	initial forever #20 ref_clk = ~ref_clk;
	task automatic finishTest();
		if (errCount == 0 && checkCount > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checkCount++;
		if (g !== e) begin
			errCount++;
			$display("CHECK FAILED %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic tmo();
		errCount++;
		$display("CHECK FAILED %0t wait ran out", $time);
		finishTest();
	endtask
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	// a channel is dropped only at the edge that saw its ready
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (int j = 0; j < 50; j++) begin
			@(posedge ref_clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (bvalid) begin
				bready <= 1'b0;
				chk(bresp, RESP_OKAY);
				return;
			end
		end
		tmo();
	endtask
	task automatic rd(input logic [11:0] a);
		@(posedge ref_clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (int j = 0; j < 50; j++) begin
			@(posedge ref_clk);
			if (arready) arvalid <= 1'b0;
			if (rvalid) begin
				rready <= 1'b0;
				rd0 = rdata;
				rr = rresp;
				return;
			end
		end
		tmo();
	endtask
	// software must see a request bit at zero before setting it again
	task automatic idle(input int b);
		for (int j = 0; j < 20; j++) begin
			rd(A_CTRL);
			if (!rd0[b]) return;
		end
		tmo();
	endtask
	// snapshot model: class table, version, carrier and address filter
	function automatic logic expSnap();
		logic [15:0] m;
		logic        enc;
		m = c[17] ? (c[16] ? 16'h000C : 16'h0003) : !c[14] ? (c[16] ? 16'h070F : 16'h0303)
			: {12'h000, c[16], c[16], c[15], !c[15]};
		enc = f[8:7] == 2'h0 ? c[13] : f[8:7] == 2'h1 ? c[12] : f[8:7] == 2'h2 && c[11] && (!c[18] || f[10]);
		return c[0] && (c[8] || f[0] && {2'h0, f[2:1]} == (c[10] ? 4'h2 : 4'h1) && enc && m[f[6:3]]);
	endfunction
	task automatic frame();
		logic [31:0] v;
		@(posedge ref_clk);
		v = rnd();
		f <= v;
		go <= 1'b1;
		tx <= v[11];
		@(posedge ref_clk);
		go <= 1'b0;
		tx <= 1'b0;
		#1;
		chk(rxSnap, expSnap());
		chk(txSnap, c[0] & f[11]);
	endtask
	// back-to-back stamps, each checked against the previous one: transmit and receive in coarse runs, transmit sub-seconds only in fine runs
	task automatic run(input int cnt, input logic fine);
		logic [31:0] e, pd;
		@(posedge ref_clk);
		tx <= 1'b1;
		go <= 1'b1;
		@(posedge ref_clk);
		for (int i = 0; i < cnt; i++) begin
			@(posedge ref_clk);
			#1;
			chk(txSnap, 1'b1);
			e = {1'b0, pu} + 32'h0000_0005;
			if (i > 0 && !fine) chk(txStampSec, e > lim ? ps + 1 : ps);
			if (i > 0 && !fine) chk(txStampSub, e > lim ? e - lim - 1 : e);
			if (i > 0 && !fine) chk(rxStampSec, e > lim ? ps + 1 : ps);
			if (i > 0 && !fine) chk(rxStampSub, e > lim ? e - lim - 1 : e);
			if (i > 1 && fine) chk(txStampSub - pu + pd, 32'h0000_0005);
			pd = txStampSub - pu;
			ps = txStampSec;
			pu = txStampSub;
		end
		@(posedge ref_clk);
		tx <= 1'b0;
		go <= 1'b0;
	endtask
	initial begin
		// an edge at time zero resets every flop of ptc_top before the first clock
		sys_rst <= 1'b1;
		repeat (4) @(posedge ref_clk);
		sys_rst <= 1'b0;
		rd(A_CTRL);
		chk(rd0, CTRL_RESET);
		rd(12'h0FF0);
		chk({rd0[29:0], rr}, 32'h0000_0002);
		wr(A_STEP, 32'h0000_0005);
		wr(A_USEC, 32'h0000_0003);
		wr(A_USUB, 32'h0000_000A);
		wr(A_CTRL, 32'h0000_2001);
		wr(A_CTRL, 32'h0000_2005);
		idle(B_LOAD);
		wr(A_CTRL, 32'h0000_2000);
		rd(A_SUB);
		rd1 = rd0;
		rd(A_SUB);
		chk(rd0, rd1);
		rd(A_SEC);
		chk(rd0, 32'h0000_0003);
		wr(A_USEC, 32'h0000_0001);
		// add then subtract the same amount: back where we started
		for (n = 0; n < 2; n++) begin
			wr(A_USUB, {n[0], 31'h0000_0004});
			wr(A_CTRL, 32'h0000_2008);
			idle(B_ADJ);
			rd(A_SEC);
			chk(rd0, 32'h0000_0004 - n);
			rd(A_SUB);
			chk(rd0, rd1 + 32'h0000_0004 - 4 * n);
		end
		// start 60 steps short of each rollover point
		for (n = 0; n < 2; n++) begin
			lim = n ? {1'b0, SUB_MAX_BIN} : {1'b0, SUB_MAX_DEC};
			c = n ? 32'h0000_2001 : 32'h0000_2201;
			wr(A_USEC, 32'h0000_0007);
			wr(A_USUB, lim - 32'h0000_012C);
			wr(A_CTRL, c | 32'h0000_0004);
			idle(B_LOAD);
			run(100, 1'b0);
			chk(ps, 32'h0000_0008);
		end
		wr(A_ADDEND, 32'h8000_0000);
		wr(A_CTRL, 32'h0000_2023);
		idle(B_ADDEND);
		run(40, 1'b1);
		wr(A_CTRL, 32'h0000_2001);
		rd(A_SEC);
		wr(A_TSEC, rd0);
		rd(A_SUB);
		rd1 = rd0 + 32'h0000_01F4;
		wr(A_TSUB, rd1);
		wr(A_CTRL, 32'h0000_2011);
		for (n = 0; n < 300 && stampIrq !== 1'b1; n++) @(posedge ref_clk);
		chk(n > 50 && n < 300, 1'b1);
		rd(A_SUB);
		chk(rd0 > rd1, 1'b1);
		rd(A_CTRL);
		chk(rd0[B_ARM], 1'b0);
		repeat (40) begin
			c = rnd() & 32'h0007_FF01;
			wr(A_CTRL, c);
			repeat (8) frame();
		end
		finishTest();
	end
endmodule
`default_nettype wire
